/* hdl/gate_timing_pkg.sv */
// Package with register map, field layout and state types for the block.
package gate_timing_pkg;
   localparam logic [4:0]  REG_BLANK_TIME  = 5'h19;
   localparam logic [4:0]  REG_REG_TOFF    = 5'h1a;
   localparam logic [4:0]  REG_SAFE_TOFF   = 5'h1b;
   localparam logic [4:0]  REG_TURNON      = 5'h1c;
   localparam logic [15:0] RESET_WORD      = 16'h0001;
   localparam int          DLY_MSB         = 15;
   localparam int          DLY_LSB         = 8;
   localparam int          PLAT_MSB        = 7;
   localparam int          PLAT_LSB        = 5;
   localparam int          DISCARD_BIT     = 1;
   localparam int          PAR_BIT         = 0;
   localparam logic [7:0]  MIN_DELAY       = 8'h0a;
   localparam logic [7:0]  DELAY_OFF       = 8'h00;
   localparam logic [2:0]  PLATEAU_FULL    = 3'h0;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [15:0] wdata;
      logic       discard;
   } reg_req_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_PLATEAU = 2'b01,
      ST_DONE    = 2'b10
   } trans_state_t;
endpackage

/* hdl/gate_timing_config_regs.sv */
// Timing configuration registers and two-level gate sequencer.
`timescale 1ns/100ps
module gate_timing_config_regs (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire gate_timing_pkg::reg_req_t req_i,
   output logic [15:0]                    rdata_o,
   output logic                           rvalid_o,
   input  wire logic                      osc_tick_i,
   input  wire logic                      spread_tick_i,
   input  wire logic                      gate_cmd_i,
   input  wire logic                      safe_off_i,
   input  wire logic                      overcurrent_i,
   output logic                           gate_on_o,
   output logic                           gate_plateau_o,
   output logic [2:0]                     plateau_sel_o,
   output logic                           blanking_o
);
   import gate_timing_pkg::*;

   logic [7:0]   blank_len_r;
   logic [7:0]   reg_dly_r;
   logic [2:0]   reg_plat_r;
   logic [7:0]   safe_dly_r;
   logic [2:0]   safe_plat_r;
   logic [7:0]   ton_dly_r;
   logic         discard_r;
   logic [15:0]  word_nxt;
   logic [7:0]   cnt_r;
   logic [7:0]   blank_cnt_r;
   logic         gate_r;
   logic         cmd_d_r;
   logic         ovc_d_r;
   logic         dir_on_r;
   trans_state_t state_r;
   logic [7:0]   sel_dly;
   logic         step_tick;

   // Register writes; reset restores the zero fields of the reset word.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blank_len_r <= RESET_WORD[DLY_MSB:DLY_LSB];
         reg_dly_r   <= RESET_WORD[DLY_MSB:DLY_LSB];
         reg_plat_r  <= RESET_WORD[PLAT_MSB:PLAT_LSB];
         safe_dly_r  <= RESET_WORD[DLY_MSB:DLY_LSB];
         safe_plat_r <= RESET_WORD[PLAT_MSB:PLAT_LSB];
         ton_dly_r   <= RESET_WORD[DLY_MSB:DLY_LSB];
      end else if (req_i.wr && !req_i.discard) begin
         if (req_i.addr == REG_BLANK_TIME) begin
            blank_len_r <= req_i.wdata[DLY_MSB:DLY_LSB];
         end else if (req_i.addr == REG_REG_TOFF) begin
            reg_dly_r  <= req_i.wdata[DLY_MSB:DLY_LSB];
            reg_plat_r <= req_i.wdata[PLAT_MSB:PLAT_LSB];
         end else if (req_i.addr == REG_SAFE_TOFF) begin
            safe_dly_r  <= req_i.wdata[DLY_MSB:DLY_LSB];
            safe_plat_r <= req_i.wdata[PLAT_MSB:PLAT_LSB];
         end else if (req_i.addr == REG_TURNON) begin
            ton_dly_r <= req_i.wdata[DLY_MSB:DLY_LSB];
         end
      end
   end

   // Remembers whether the last message was discarded.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         discard_r <= 1'b0;
      end else if (req_i.wr || req_i.rd) begin
         discard_r <= req_i.discard;
      end
   end

   // Builds the read word; reserved bits stay zero.
   always_comb begin
      word_nxt = 16'h0000;
      if (req_i.addr == REG_BLANK_TIME) begin
         word_nxt[DLY_MSB:DLY_LSB] = blank_len_r;
      end else if (req_i.addr == REG_REG_TOFF) begin
         word_nxt[DLY_MSB:DLY_LSB]   = reg_dly_r;
         word_nxt[PLAT_MSB:PLAT_LSB] = reg_plat_r;
      end else if (req_i.addr == REG_SAFE_TOFF) begin
         word_nxt[DLY_MSB:DLY_LSB]   = safe_dly_r;
         word_nxt[PLAT_MSB:PLAT_LSB] = safe_plat_r;
      end else if (req_i.addr == REG_TURNON) begin
         word_nxt[DLY_MSB:DLY_LSB] = ton_dly_r;
      end
      word_nxt[DISCARD_BIT] = discard_r;
      word_nxt[PAR_BIT] = ~(^word_nxt[15:1]);
   end

   // Registered read answer, one cycle after the request.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o  <= RESET_WORD;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            rdata_o <= word_nxt;
         end
      end
   end

   // Overcurrent blanking window counted in oscillator ticks.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blank_cnt_r <= 8'h00;
         ovc_d_r     <= 1'b0;
         blanking_o  <= 1'b0;
      end else begin
         ovc_d_r <= overcurrent_i;
         if (overcurrent_i && !ovc_d_r && blank_len_r != DELAY_OFF) begin
            blank_cnt_r <= blank_len_r;
            blanking_o  <= 1'b1;
         end else if (blanking_o && osc_tick_i) begin
            if (blank_cnt_r <= 8'h01) begin
               blanking_o <= 1'b0;
            end
            blank_cnt_r <= blank_cnt_r - 8'h01;
         end
      end
   end

   // Delay for a transition about to start, and the tick that paces it.
   always_comb begin
      sel_dly   = gate_cmd_i ? ton_dly_r
                  : (safe_off_i ? safe_dly_r : reg_dly_r);
      step_tick = dir_on_r ? spread_tick_i : osc_tick_i;
   end

   // Two-level sequencer: plateau for the delay, then full level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r        <= ST_IDLE;
         cnt_r          <= 8'h00;
         cmd_d_r        <= 1'b0;
         dir_on_r       <= 1'b0;
         gate_r         <= 1'b0;
         gate_on_o      <= 1'b0;
         gate_plateau_o <= 1'b0;
         plateau_sel_o  <= PLATEAU_FULL;
      end else begin
         cmd_d_r   <= gate_cmd_i;
         gate_on_o <= gate_r;
         case (state_r)
            ST_IDLE: begin
               if (gate_cmd_i != cmd_d_r) begin
                  dir_on_r <= gate_cmd_i;
                  // A zero delay skips the plateau entirely.
                  if (sel_dly == DELAY_OFF) begin
                     gate_r <= gate_cmd_i;
                  end else begin
                     cnt_r <= sel_dly;
                     plateau_sel_o <= safe_off_i ? safe_plat_r
                                      : reg_plat_r;
                     gate_plateau_o <= 1'b1;
                     state_r <= ST_PLATEAU;
                  end
               end
            end
            ST_PLATEAU: begin
               if (step_tick) begin
                  cnt_r <= cnt_r - 8'h01;
                  if (cnt_r <= 8'h01) begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               gate_r         <= dir_on_r;
               gate_plateau_o <= 1'b0;
               plateau_sel_o  <= PLATEAU_FULL;
               state_r        <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Checks on parity, reserved bits, blanking and sequencing.
   a_read_parity: assert property (@(posedge clk_i) disable iff (rst_i)
      rvalid_o |-> ^rdata_o)
      else $error("Read word parity is not odd.");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      rvalid_o |-> rdata_o[4:2] == 3'h0)
      else $error("Reserved bits read as nonzero.");
   a_discard_report: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i.rd |=> rdata_o[DISCARD_BIT] == $past(discard_r))
      else $error("Discard flag not reported.");
   a_blank_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (blank_len_r == DELAY_OFF && !blanking_o) |=> !blanking_o)
      else $error("Blanking started while disabled.");
   a_blank_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (overcurrent_i && !ovc_d_r && blank_len_r != DELAY_OFF) |=> blanking_o)
      else $error("Blanking did not start.");
   a_plateau_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_PLATEAU && !step_tick) |=> state_r == ST_PLATEAU)
      else $error("Plateau left without a tick.");
   a_ton_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && gate_cmd_i && !cmd_d_r
       && ton_dly_r == DELAY_OFF) |=> !gate_plateau_o ##1 gate_on_o)
      else $error("Disabled turn-on used a plateau.");
   a_safe_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && !gate_cmd_i && cmd_d_r && safe_off_i
       && safe_dly_r == DELAY_OFF) |=> !gate_plateau_o)
      else $error("Disabled safe turn-off used a plateau.");
   a_safe_plateau: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && !gate_cmd_i && cmd_d_r && safe_off_i
       && safe_dly_r != DELAY_OFF) |=> plateau_sel_o == $past(safe_plat_r))
      else $error("Wrong safe plateau selected.");
   c_plateau: cover property (@(posedge clk_i) state_r == ST_DONE);
   c_blank: cover property (@(posedge clk_i) $fell(blanking_o));
   c_discard: cover property (@(posedge clk_i) rvalid_o && rdata_o[1]);
endmodule

/* sim/spi_host_model.sv */
// Host model that issues register messages to the configuration block.
`timescale 1ns/100ps
module spi_host_model (
   input  wire logic                 clk_i,
   input  wire logic [15:0]          rdata_i,
   input  wire logic                 rvalid_i,
   output gate_timing_pkg::reg_req_t req_o
);
   import gate_timing_pkg::*;

   // The request stays idle outside messages.
   initial req_o = '0;

   // One write message; callers keep used delays at ten or more.
   task automatic wr(input logic [4:0] a, input logic [15:0] d,
                     input logic x);
      @(posedge clk_i) req_o <= '{1'b1, 1'b0, a, d, x};
      @(posedge clk_i) req_o <= '0;
   endtask

   // One read message; the word is taken at the edge where it is valid.
   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge clk_i) req_o <= '{1'b0, 1'b1, a, 16'h0000, 1'b0};
      @(posedge clk_i) req_o <= '0;
      @(posedge clk_i);
      q = rvalid_i ? rdata_i : 16'hxxxx;
   endtask
endmodule

/* sim/gate_timing_config_regs_tb.sv */
// Self-checking bench for the timing configuration registers.
`timescale 1ns/100ps
module gate_timing_config_regs_tb;
   import gate_timing_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        osc_i = 1'b1;
   logic        spr_i = 1'b1;
   logic        cmd_i = 1'b0;
   logic        safe_i = 1'b0;
   logic        ovc_i = 1'b0;
   logic [2:0]  ph = 3'h0;
   reg_req_t    req;
   logic [15:0] rdata, q;
   logic        rvalid, on, plat, blank;
   logic [2:0]  sel, ps;
   int          miscompares = 0, checks = 0, nb = 0, np = 0;

   gate_timing_config_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
      .rdata_o(rdata), .rvalid_o(rvalid), .osc_tick_i(osc_i),
      .spread_tick_i(spr_i), .gate_cmd_i(cmd_i), .safe_off_i(safe_i),
      .overcurrent_i(ovc_i), .gate_on_o(on), .gate_plateau_o(plat),
      .plateau_sel_o(sel), .blanking_o(blank));
   spi_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
      .req_o(req));

   always #12.5 clk_i = ~clk_i;

   // Oscillator ticks every second cycle, spread ticks every third cycle.
   always @(posedge clk_i) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      osc_i <= ph[0];
      spr_i <= (ph == 3'h1 || ph == 3'h4);
   end

   // Counts pacing ticks seen in blanking and plateau; keeps plateau code.
   always @(posedge clk_i) begin
      if (blank && osc_i) nb++;
      if (plat) begin
         if (cmd_i ? spr_i : osc_i) np++;
         ps = sel;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] ex);
      checks++;
      if (got !== ex) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, ex);
      end
   endtask

   // Expected read word: fields kept, reserved zero, odd parity.
   function automatic logic [15:0] expw(input logic [4:0] a,
                                        input logic [15:0] d, input logic l);
      logic [15:0] w;
      w = {d[15:8], 8'h00};
      if (a == REG_REG_TOFF || a == REG_SAFE_TOFF) w[7:5] = d[7:5];
      w[1] = l;
      w[0] = ~^w;
      return w;
   endfunction

   task automatic t_regs;
      logic [4:0] m [4] = '{REG_BLANK_TIME, REG_REG_TOFF, REG_SAFE_TOFF,
                            REG_TURNON};
      foreach (m[i]) begin
         host.rd(m[i], q);
         chk(q, RESET_WORD);
         host.wr(m[i], 16'hffff, 1'b0);
         host.rd(m[i], q);
         chk(q, expw(m[i], 16'hffff, 1'b0));
      end
      host.wr(REG_SAFE_TOFF, 16'h0a40, 1'b1);
      host.rd(REG_SAFE_TOFF, q);
      chk(q, expw(REG_SAFE_TOFF, 16'hffff, 1'b1));
      host.rd(REG_SAFE_TOFF, q);
      chk(q, expw(REG_SAFE_TOFF, 16'hffff, 1'b0));
      host.rd(5'h00, q);
      chk(q, 16'h0001);
      $display("register test done");
   endtask

   // Blanking length in oscillator ticks for one programmed value.
   task automatic blank_run(input logic [7:0] v);
      host.wr(REG_BLANK_TIME, {v, 8'h00}, 1'b0);
      nb = 0;
      ovc_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      ovc_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(16'(nb), 16'(v));
   endtask

   // One gate transition with its expected plateau tick count and code.
   task automatic gate(input logic c, input logic s, input logic [7:0] n,
                       input logic [2:0] e);
      np = 0;
      ps = 3'h0;
      @(posedge clk_i) cmd_i <= c;
      safe_i <= s;
      repeat (50) @(posedge clk_i);
      chk(16'(on), 16'(c));
      chk(16'(np), 16'(n));
      if (!c) chk(16'(ps), 16'(e));
   endtask

   task automatic t_gate;
      host.wr(REG_TURNON, 16'h0a00, 1'b0);
      host.wr(REG_SAFE_TOFF, 16'h0c60, 1'b0);
      host.wr(REG_REG_TOFF, 16'h0a80, 1'b0);
      gate(1'b1, 1'b0, 8'h0a, 3'h0);
      gate(1'b0, 1'b1, 8'h0c, 3'h3);
      gate(1'b1, 1'b0, 8'h0a, 3'h0);
      gate(1'b0, 1'b0, 8'h0a, 3'h4);
      host.wr(REG_TURNON, 16'h0000, 1'b0);
      host.wr(REG_SAFE_TOFF, 16'h0000, 1'b0);
      gate(1'b1, 1'b0, 8'h00, 3'h0);
      gate(1'b0, 1'b1, 8'h00, 3'h0);
      $display("gate test done");
   endtask

   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence after three reset cycles.
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      blank_run(8'h0a);
      blank_run(8'h00);
      $display("blanking test done");
      t_gate();
      final_report();
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #(25 * 5000);
      miscompares++;
      final_report();
   end
endmodule
